// *** hw/fpec_defines.vh ***
// Register map, field positions, reset values and timing for the flash program/erase control block
`ifndef FPEC_DEFINES_VH
`define FPEC_DEFINES_VH

// Avalon word addresses (one register per 32-bit word)
`define FPEC_ADDR_MODE_CTRL 3'h0
`define FPEC_ADDR_ERR_STATUS 3'h1
`define FPEC_ADDR_BLK_LOW 3'h2
`define FPEC_ADDR_BLK_HIGH 3'h3
`define FPEC_ADDR_OVERLAY 3'h4
`define FPEC_ADDR_SYS_CTRL 3'h5
`define FPEC_ADDR_MAP_STATUS 3'h6

// Mode control fields
`define FPEC_MC_WE_PIN 7
`define FPEC_MC_SWE 6
`define FPEC_MC_ESU 5
`define FPEC_MC_PSU 4
`define FPEC_MC_EV 3
`define FPEC_MC_PV 2
`define FPEC_MC_EGO 1
`define FPEC_MC_PGO 0

// Error status and overlay fields
`define FPEC_ES_ERR 7
`define FPEC_OV_SEL 3
`define FPEC_OV_AREA_HI 2

// System control fields (power states and flash disable set by software)
`define FPEC_SC_HW_STBY 0
`define FPEC_SC_SW_STBY 1
`define FPEC_SC_FLASH_OFF 2

// Reset values
`define FPEC_RST_BYTE 8'h00
`define FPEC_RST_OVERLAY 16'h0000
`define FPEC_RST_HIGH_MASK 8'h0F

// Address map
`define FPEC_RAM_WIN_BASE 32'hFFFF8000
`define FPEC_RAM_WIN_LAST 32'hFFFF8FFF
`define FPEC_SMALL_BLK_SHIFT 12
`define FPEC_BLK8_BASE 32'h00008000
`define FPEC_BLK9_BASE 32'h00010000
`define FPEC_BIG_BLK_SHIFT 16

// Access time in clock cycles
`define FPEC_BYTE_CYCLES 3
`define FPEC_LONG_CYCLES 6

`endif

// *** hw/fpec_block_map.v ***
// Decodes the one-hot erase selection into an address range and flags multi-select
`timescale 1ns/1ps
module fpec_block_map (
    // Selection
    input wire [7:0] sel_low,
    input wire [3:0] sel_high,
    // Result
    output reg [31:0] blk_base,
    output reg [31:0] blk_last,
    output wire multi_sel,
    output wire any_sel
);
    `include "fpec_defines.vh"
    wire [11:0] all_sel;
    reg [3:0] ones;
    integer i;

    assign all_sel = {sel_high, sel_low};
    assign any_sel = |all_sel;
    assign multi_sel = (ones > 4'h1);

    // Population count and range lookup
    always @* begin
        ones = 4'h0;
        blk_base = 32'h00000000;
        blk_last = 32'h00000000;
        for (i = 0; i < 12; i = i + 1) begin
            ones = ones + {3'h0, all_sel[i]};
        end
        for (i = 0; i < 8; i = i + 1) begin
            if (sel_low[i]) begin
                blk_base = i << `FPEC_SMALL_BLK_SHIFT;
                blk_last = ((i + 1) << `FPEC_SMALL_BLK_SHIFT) - 1;
            end
        end
        if (sel_high[0]) begin
            blk_base = `FPEC_BLK8_BASE;
            blk_last = `FPEC_BLK9_BASE - 32'h1;
        end
        for (i = 1; i < 4; i = i + 1) begin
            if (sel_high[i]) begin
                blk_base = i << `FPEC_BIG_BLK_SHIFT;
                blk_last = ((i + 1) << `FPEC_BIG_BLK_SHIFT) - 1;
            end
        end
    end
endmodule

// *** hw/fpec_ctrl.v ***
// Flash program/erase control registers with an Avalon-MM slave
// Function
// - Erase go needs pin, soft enable, setup
// - Program go needs pin, soft enable, setup
// - Error status cleared by reset, hardware standby
// - Flash disabled: registers 0..3 read zero, mode/select writes ignored
// - Error flag set on error, blocks operations
// - Error flag cleared only by reset/hardware standby
// - Low block register held zero when unenabled
// - Only selected block may be erased
// - Multiple selects clear both block registers
// - High block bits cleared without soft enable
// - Low selects map eight 4 kB blocks
// - High selects map 32 kB, three 64 kB
// - Overlay kept through software standby only
// - Emulation select blocks program and erase
// - Emulation off leaves RAM window plain
// - Emulation on overlays selected 4 kB block
// - Top mode bit mirrors write-enable pin
// - Write gating by pin and soft enable
// - Byte access 3 cycles, longword 6
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
// Constants are needed by the parameter defaults, so they come in before the header
`include "fpec_defines.vh"
module fpec_ctrl #(
    parameter BYTE_CYCLES = `FPEC_BYTE_CYCLES,
    parameter LONG_CYCLES = `FPEC_LONG_CYCLES
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Avalon-MM slave
    input wire [2:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // Flash pins and events
    input wire write_enable_pin,
    input wire flash_error_event,
    // Flash array controls
    output wire program_active,
    output wire erase_active,
    output wire program_verify,
    output wire erase_verify,
    output wire erase_allowed,
    output reg [31:0] erase_base,
    output reg [31:0] erase_last,
    // RAM overlay
    output reg overlay_active,
    output reg [31:0] overlay_flash_base
);

    // Register map, one register per bus word, all in byte lane 0
    //   0 mode control: pin mirror, soft enable, setups, verifies, go bits
    //   1 error status: error flag in bit 7, the rest read zero
    //   2 low erase select: one bit per 4 kB block
    //   3 high erase select: bits 3..0 for the large blocks
    //   4 overlay control: select in bit 3, area in bits 2..0
    //   5 system control: standby states and flash disable
    //   6 map status: multi select, any select, erase allowed
    //   7 unmapped, reads zero
    //
    // Access timing
    //   Every access stalls with waitrequest until the count is reached.
    //   Byte registers take the short count, a longword overlay access
    //   the long count. The done flag keeps a request that stays high
    //   from being taken twice in a row; it restarts instead.
    //
    // Mode gating
    //   The soft enable is only writable with the pin high. The setup
    //   and verify bits need the soft enable as well. A go bit needs
    //   its setup bit already in the register, so a write that sets
    //   setup and go together leaves go clear. Software must not rely
    //   on that write; it is a sequencing fault on its side.
    //   Dropping the pin clears the whole mode register at once, and
    //   dropping the soft enable clears bits 5..0.
    //
    // Erase selection
    //   Both select registers follow the soft enable: without it they
    //   are held at zero. If two or more select bits are ever set
    //   together, both registers are cleared on the next edge. For
    //   that one cycle the erase output is masked by the multi flag,
    //   so a double selection can never reach the array.
    //
    // Protection
    //   Any of the error flag, the overlay select or a low pin blocks
    //   program and erase. The error flag is sticky: only reset and
    //   hardware standby clear it, software writes have no effect.
    //   The flag is set only by an error while an operation runs.
    //
    // Standby
    //   Hardware standby clears error, mode, selects and overlay.
    //   Software standby clears mode and selects, keeps the overlay.
    //
    // Overlay
    //   The range and overlay outputs are registered and follow the
    //   register contents one cycle late. Software must leave a gap
    //   before touching the overlaid area after a change; the block
    //   gives no guarantee for the access right after the write.
    //
    // Limitations
    //   No timing algorithm is kept here; the program and erase pulse
    //   lengths are software's business. Only lane 0 is decoded, so a
    //   write on other lanes alone has no effect.

    reg [6:0] mode_ff;
    reg [6:0] nxt_mode;
    reg err_ff;
    reg [7:0] blk_low_ff;
    reg [7:0] nxt_blk_low;
    reg [3:0] blk_high_ff;
    reg [3:0] nxt_blk_high;
    reg [3:0] overlay_ff;
    reg [2:0] sys_ff;
    reg [2:0] wait_cnt_ff;
    reg [2:0] nxt_wait_cnt;
    reg done_ff;
    reg [31:0] rd_value;
    reg [2:0] need_cycles;
    reg [7:0] wbyte;
    reg [7:0] low_candidate;
    reg [3:0] high_candidate;
    wire req;
    wire take;
    wire wr_take;
    wire flash_off;
    wire hw_stby;
    wire sw_stby;
    wire soft_en;
    wire multi_sel;
    wire any_sel;
    wire protect;
    wire [31:0] map_base;
    wire [31:0] map_last;

    assign req = avs_read | avs_write;
    assign flash_off = sys_ff[`FPEC_SC_FLASH_OFF];
    assign hw_stby = sys_ff[`FPEC_SC_HW_STBY];
    assign sw_stby = sys_ff[`FPEC_SC_SW_STBY];
    assign soft_en = write_enable_pin & mode_ff[`FPEC_MC_SWE];
    // Request completes when the access count is reached
    assign take = req & (wait_cnt_ff == need_cycles - 3'h1) & ~done_ff;
    assign avs_waitrequest = req & ~take;
    assign wr_take = take & avs_write & ~flash_off;

    // Byte vs longword timing
    always @* begin
        need_cycles = BYTE_CYCLES[2:0];
        if ((avs_address == `FPEC_ADDR_OVERLAY) && (&avs_byteenable)) begin
            need_cycles = LONG_CYCLES[2:0];
        end
    end

    // Access cycle counter
    always @* begin
        nxt_wait_cnt = wait_cnt_ff;
        if (!req || take) begin
            nxt_wait_cnt = 3'h0;
        end else begin
            nxt_wait_cnt = wait_cnt_ff + 3'h1;
        end
    end

    // Only lane 0 carries byte registers; other lanes are accepted but ignored
    always @* begin
        wbyte = avs_writedata[7:0];
    end

    // Mode register next state with gating
    always @* begin
        nxt_mode = mode_ff;
        if (wr_take && avs_address == `FPEC_ADDR_MODE_CTRL && avs_byteenable[0]) begin
            if (write_enable_pin) begin
                nxt_mode[`FPEC_MC_SWE] = wbyte[`FPEC_MC_SWE];
            end
            if (soft_en) begin
                nxt_mode[`FPEC_MC_ESU] = wbyte[`FPEC_MC_ESU];
                nxt_mode[`FPEC_MC_PSU] = wbyte[`FPEC_MC_PSU];
                nxt_mode[`FPEC_MC_EV] = wbyte[`FPEC_MC_EV];
                nxt_mode[`FPEC_MC_PV] = wbyte[`FPEC_MC_PV];
            end
            // Go bits check the setup bit already held; same-write setting is software's fault
            nxt_mode[`FPEC_MC_EGO] = wbyte[`FPEC_MC_EGO] & soft_en & mode_ff[`FPEC_MC_ESU];
            nxt_mode[`FPEC_MC_PGO] = wbyte[`FPEC_MC_PGO] & soft_en & mode_ff[`FPEC_MC_PSU];
        end
        if (!write_enable_pin) begin
            nxt_mode = 7'h00;
        end else if (!nxt_mode[`FPEC_MC_SWE]) begin
            nxt_mode[5:0] = 6'h00;
        end
        // Go bits drop as soon as their setup bit drops
        if (!nxt_mode[`FPEC_MC_ESU]) begin
            nxt_mode[`FPEC_MC_EGO] = 1'b0;
        end
        if (!nxt_mode[`FPEC_MC_PSU]) begin
            nxt_mode[`FPEC_MC_PGO] = 1'b0;
        end
    end

    // Erase block registers with one-hot check
    always @* begin
        low_candidate = blk_low_ff;
        high_candidate = blk_high_ff;
        if (wr_take && avs_address == `FPEC_ADDR_BLK_LOW && avs_byteenable[0] && soft_en) begin
            low_candidate = wbyte;
        end
        if (wr_take && avs_address == `FPEC_ADDR_BLK_HIGH && avs_byteenable[0] && soft_en) begin
            high_candidate = wbyte[3:0];
        end
        nxt_blk_low = low_candidate;
        nxt_blk_high = high_candidate;
        if (!soft_en) begin
            nxt_blk_low = `FPEC_RST_BYTE;
            nxt_blk_high = 4'h0;
        end
    end

    fpec_block_map u_map (
        .sel_low(blk_low_ff),
        .sel_high(blk_high_ff),
        .blk_base(map_base),
        .blk_last(map_last),
        .multi_sel(multi_sel),
        .any_sel(any_sel)
    );

    // Registers; the multi-select clear lands one cycle after the bad write
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_ff <= 7'h00;
            err_ff <= 1'b0;
            blk_low_ff <= `FPEC_RST_BYTE;
            blk_high_ff <= 4'h0;
            overlay_ff <= 4'h0;
            sys_ff <= 3'h0;
            wait_cnt_ff <= 3'h0;
            done_ff <= 1'b0;
        end else begin
            wait_cnt_ff <= nxt_wait_cnt;
            done_ff <= take;
            if (take && avs_write && avs_address == `FPEC_ADDR_SYS_CTRL && avs_byteenable[0]) begin
                sys_ff <= wbyte[2:0];
            end
            if (hw_stby) begin
                err_ff <= 1'b0;
            end else if (flash_error_event && (program_active || erase_active)) begin
                err_ff <= 1'b1;
            end
            if (hw_stby || sw_stby) begin
                mode_ff <= 7'h00;
                blk_low_ff <= `FPEC_RST_BYTE;
                blk_high_ff <= 4'h0;
            end else begin
                mode_ff <= nxt_mode;
                if (multi_sel) begin
                    blk_low_ff <= `FPEC_RST_BYTE;
                    blk_high_ff <= 4'h0;
                end else begin
                    blk_low_ff <= nxt_blk_low;
                    blk_high_ff <= nxt_blk_high;
                end
            end
            // Overlay survives software standby
            if (hw_stby) begin
                overlay_ff <= 4'h0;
            end else if (take && avs_write && avs_address == `FPEC_ADDR_OVERLAY && avs_byteenable[0]) begin
                overlay_ff <= wbyte[3:0];
            end
        end
    end

    // Protection and array controls
    assign protect = err_ff | overlay_ff[`FPEC_OV_SEL] | ~write_enable_pin;
    assign program_active = mode_ff[`FPEC_MC_PGO] & ~protect;
    assign erase_active = mode_ff[`FPEC_MC_EGO] & ~protect & any_sel & ~multi_sel;
    assign program_verify = mode_ff[`FPEC_MC_PV];
    assign erase_verify = mode_ff[`FPEC_MC_EV];
    // Per-block erase enables; a block counts only while it alone is selected
    wire [11:0] blk_sel_all;
    wire [11:0] blk_erase_en;
    assign blk_sel_all = {blk_high_ff, blk_low_ff};
    genvar g;
    generate
        for (g = 0; g < 12; g = g + 1) begin : g_blk
            assign blk_erase_en[g] = blk_sel_all[g] & ~multi_sel & ~protect;
        end
    endgenerate
    assign erase_allowed = |blk_erase_en;

    // Registered range and overlay outputs
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            erase_base <= 32'h00000000;
            erase_last <= 32'h00000000;
            overlay_active <= 1'b0;
            overlay_flash_base <= 32'h00000000;
        end else begin
            erase_base <= map_base;
            erase_last <= map_last;
            overlay_active <= overlay_ff[`FPEC_OV_SEL];
            // Window at the RAM base maps onto 4 kB block n when active
            overlay_flash_base <= {17'h0, overlay_ff[`FPEC_OV_AREA_HI:0], 12'h000};
        end
    end

    // Read mux
    always @* begin
        rd_value = 32'h00000000;
        case (avs_address)
            `FPEC_ADDR_MODE_CTRL: rd_value = {24'h0, write_enable_pin, mode_ff};
            `FPEC_ADDR_ERR_STATUS: rd_value = {24'h0, err_ff, 7'h00};
            `FPEC_ADDR_BLK_LOW: rd_value = {24'h0, blk_low_ff};
            `FPEC_ADDR_BLK_HIGH: rd_value = {28'h0, blk_high_ff};
            `FPEC_ADDR_OVERLAY: rd_value = {28'h0, overlay_ff};
            `FPEC_ADDR_SYS_CTRL: rd_value = {29'h0, sys_ff};
            `FPEC_ADDR_MAP_STATUS: rd_value = {29'h0, multi_sel, any_sel, erase_allowed};
            default: rd_value = 32'h00000000;
        endcase
        if (flash_off && avs_address <= `FPEC_ADDR_BLK_HIGH) begin
            rd_value = 32'h00000000;
        end
    end

    // Read data driven combinationally in the accepting cycle, zero while waitrequest is high
    always @* begin
        avs_readdata = take ? rd_value : 32'h00000000;
    end
endmodule

// *** tb/fpec_ctrl_asserts.sv ***
// Checker of bus timing and decode relations for the flash program/erase control block
`timescale 1ns/1ps
module fpec_ctrl_asserts #(
    parameter BYTE_CYCLES = 3,
    parameter LONG_CYCLES = 6
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Avalon-MM slave
    input wire [2:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // Flash pins and array controls
    input wire write_enable_pin,
    input wire flash_error_event,
    input wire program_active,
    input wire erase_active,
    input wire program_verify,
    input wire erase_verify,
    input wire erase_allowed,
    input wire [31:0] erase_base,
    input wire [31:0] erase_last,
    // RAM overlay
    input wire overlay_active,
    input wire [31:0] overlay_flash_base
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Request decode shared by the timing and read-back checks
    wire req = avs_read | avs_write;
    wire lng = avs_address == 3'h4 && avs_byteenable == 4'hF;
    wire rdone = avs_read && !avs_waitrequest;
    logic [3:0] wcnt_ff;
    // Counts stalled cycles so the access length can be held to the parameter
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wcnt_ff <= 4'h0;
        end else begin
            wcnt_ff <= (req && avs_waitrequest) ? wcnt_ff + 4'h1 : 4'h0;
        end
    end
    a_wait_byte: assert property (
        $rose(req) && !lng |-> avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest) else $error("byte wait");
    a_wait_len: assert property (
        req && !avs_waitrequest |-> wcnt_ff == (lng ? LONG_CYCLES - 1 : BYTE_CYCLES - 1)) else $error("wait length");
    a_erase_gate: assert property (
        $rose(erase_active) |-> $past(write_enable_pin && avs_write && !avs_waitrequest && avs_writedata[1]))
        else $error("erase rise");
    a_prog_gate: assert property (
        $rose(program_active) |-> $past(write_enable_pin && avs_write && !avs_waitrequest && avs_writedata[0]))
        else $error("program rise");
    a_pin_drop: assert property (
        !write_enable_pin ##1 !write_enable_pin |=> !erase_active && !program_active) else $error("pin low");
    a_ovl_protect: assert property (
        overlay_active && $past(overlay_active) |-> !erase_allowed) else $error("overlay protect");
    a_blk_size: assert property (
        erase_last != 32'h0 |-> erase_last <= 32'h3FFFF && erase_last - erase_base ==
        (erase_base < 32'h8000 ? 32'hFFF : (erase_base == 32'h8000 ? 32'h7FFF : 32'hFFFF))) else $error("block size");
    a_ovl_base: assert property (
        overlay_active |-> overlay_flash_base[11:0] == 12'h000 && overlay_flash_base < 32'h8000)
        else $error("overlay base");
    a_stat_resv: assert property (
        rdone && avs_address == 3'h1 |-> avs_readdata[6:0] == 7'h00) else $error("status reserved");
    a_pin_mirror: assert property (
        rdone && avs_address == 3'h0 && avs_readdata[7] |-> write_enable_pin || $past(write_enable_pin))
        else $error("pin mirror");
endmodule

bind fpec_ctrl fpec_ctrl_asserts #(.BYTE_CYCLES(BYTE_CYCLES), .LONG_CYCLES(LONG_CYCLES)) u_chk (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .write_enable_pin(write_enable_pin), .flash_error_event(flash_error_event),
    .program_active(program_active), .erase_active(erase_active), .program_verify(program_verify),
    .erase_verify(erase_verify), .erase_allowed(erase_allowed), .erase_base(erase_base), .erase_last(erase_last),
    .overlay_active(overlay_active), .overlay_flash_base(overlay_flash_base));

// *** tb/tb.sv ***
// Self-checking bench for the flash program/erase control block
`timescale 1ns/1ps
module tb;
    // Stimulus and observed outputs
    logic clk = 1'b0, rst = 1'b1, rd_s = 1'b0, wr_s = 1'b0, pin = 1'b1, err_ev = 1'b0;
    logic [2:0] adr = 3'h0;
    logic [3:0] be = 4'h1;
    logic [31:0] wd = 32'h0, rdata, e_base, e_last, o_base, q, eb;
    logic wreq, p_act, e_act, p_ver, e_ver, e_ok, o_act;
    int n_fail = 0, tests_run = 0, cyc = 0, i;
    fpec_ctrl DUT (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
        .avs_byteenable(be), .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wreq),
        .write_enable_pin(pin), .flash_error_event(err_ev), .program_active(p_act), .erase_active(e_act),
        .program_verify(p_ver), .erase_verify(e_ver), .erase_allowed(e_ok), .erase_base(e_base),
        .erase_last(e_last), .overlay_active(o_act), .overlay_flash_base(o_base));
    // 200 MHz clock
    always #2.5 clk = ~clk;
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end
    task final_report();
        if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One bus access; request held until waitrequest is seen low at a rising edge
    task acc(input [2:0] a, input w, input [31:0] d, input [3:0] b);
        int k;
        @(posedge clk);
        adr <= a;
        wd <= d;
        be <= b;
        wr_s <= w;
        rd_s <= !w;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (wreq === 1'b0) break;
        end
        q = rdata;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        #1;
    endtask
    task wr(input [2:0] a, input [31:0] d);
        acc(a, 1'b1, d, 4'h1);
    endtask
    task rd(input [2:0] a, input [31:0] exp, input string nm);
        acc(a, 1'b0, 32'h0, 4'h1);
        chk(nm, exp, q);
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(3'h0, 32'h80, "mode_rst");
        rd(3'h1, 32'h00, "status_rst");
        rd(3'h4, 32'h00, "ovl_rst");
        rd(3'h7, 32'h00, "unmapped");
        @(posedge clk) pin <= 1'b0;
        wr(3'h0, 32'h40);
        rd(3'h0, 32'h00, "mode_pin_low");
        @(posedge clk) pin <= 1'b1;
        wr(3'h0, 32'h40);
        wr(3'h0, 32'h48);
        chk("erase_verify", 32'h1, e_ver);
        // Go bit with its setup in the same write is refused, accepted once setup stands
        wr(3'h2, 32'h01);
        for (i = 0; i < 2; i++) begin
            wr(3'h0, i ? 32'h51 : 32'h62);
            rd(3'h0, i ? 32'hD0 : 32'hE0, "go_same_write");
            wr(3'h0, i ? 32'h51 : 32'h62);
            chk("go_active", 32'h1, i ? p_act : e_act);
            wr(3'h0, 32'h40);
        end
        // Error during erase blocks it and survives all but hardware standby
        wr(3'h2, 32'h01);
        chk("sel_allowed", 32'h1, e_ok);
        wr(3'h0, 32'h60);
        wr(3'h0, 32'h62);
        @(posedge clk) err_ev <= 1'b1;
        @(posedge clk) err_ev <= 1'b0;
        rd(3'h1, 32'h80, "err_set");
        chk("err_blocks", 32'h0, e_ok);
        wr(3'h1, 32'h00);
        wr(3'h5, 32'h2);
        wr(3'h5, 32'h0);
        rd(3'h1, 32'h80, "err_sw_stby");
        rd(3'h2, 32'h00, "low_sw_stby");
        wr(3'h5, 32'h1);
        wr(3'h5, 32'h0);
        rd(3'h1, 32'h00, "err_hw_stby");
        // Every block decodes to its own range
        wr(3'h0, 32'h40);
        for (i = 0; i < 12; i++) begin
            wr(3'h2, 32'h0);
            wr(3'h3, 32'h0);
            wr(i < 8 ? 3'h2 : 3'h3, 32'h1 << (i % 8));
            repeat (2) @(posedge clk);
            #1;
            eb = i < 8 ? i * 32'h1000 : (i == 8 ? 32'h8000 : (i - 8) * 32'h10000);
            chk("blk_base", eb, e_base);
            chk("blk_last", eb + (i < 8 ? 32'hFFF : (i == 8 ? 32'h7FFF : 32'hFFFF)), e_last);
            chk("blk_allowed", 32'h1, e_ok);
        end
        wr(3'h3, 32'hF4);
        rd(3'h3, 32'h04, "high_resv");
        wr(3'h2, 32'h01);
        rd(3'h2, 32'h00, "multi_low");
        rd(3'h3, 32'h00, "multi_high");
        wr(3'h3, 32'h02);
        wr(3'h0, 32'h00);
        rd(3'h3, 32'h00, "high_no_swe");
        wr(3'h0, 32'h40);
        wr(3'h2, 32'h10);
        @(posedge clk) pin <= 1'b0;
        rd(3'h2, 32'h00, "low_pin_low");
        @(posedge clk) pin <= 1'b1;
        // Overlay: long access, reserved bits, protection, standby behaviour
        wr(3'h0, 32'h40);
        wr(3'h2, 32'h01);
        acc(3'h4, 1'b1, 32'hFFFFFFFF, 4'hF);
        acc(3'h4, 1'b0, 32'h0, 4'hF);
        chk("ovl_read", 32'h0F, q);
        chk("ovl_on", 32'h1, o_act);
        chk("ovl_base7", 32'h7000, o_base);
        chk("ovl_protect", 32'h0, e_ok);
        wr(3'h4, 32'h0D);
        wr(3'h5, 32'h2);
        wr(3'h5, 32'h0);
        rd(3'h4, 32'h0D, "ovl_sw_stby");
        chk("ovl_base5", 32'h5000, o_base);
        wr(3'h4, 32'h05);
        rd(3'h4, 32'h05, "ovl_off_rd");
        chk("ovl_off", 32'h0, o_act);
        wr(3'h4, 32'h08);
        wr(3'h5, 32'h1);
        wr(3'h5, 32'h0);
        rd(3'h4, 32'h00, "ovl_hw_stby");
        // Flash disabled: reads zero, writes dropped
        wr(3'h5, 32'h4);
        rd(3'h0, 32'h00, "off_read");
        wr(3'h0, 32'h40);
        wr(3'h5, 32'h0);
        rd(3'h0, 32'h80, "off_write");
        final_report();
    end
endmodule
